// ===== hdl/mem_device.sv
// Memory device end of the serial link: register frames, init tracking,
// erase/write/read of a 256 x 32 word store. Clocked by the link clock; the test-mode sync and monitor_halted run on pclk.
// Assumes the host keeps the clock low when select falls.
`timescale 1ns/100ps
module mem_device #(
  parameter int ADDR_BITS = spi_seq_pkg::MEM_ADDR_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  spi_link_if.device link,
  output logic monitor_halted,
  output logic link_ready,
  output logic powered_down
);
  localparam int DEPTH = 1 << ADDR_BITS;

  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_WOKEN = 7'h02,
    ST_WAKE_CLR = 7'h04,
    ST_SLEPT = 7'h08,
    ST_CTRL_CLR = 7'h10,
    ST_ADDR_CLR = 7'h20,
    ST_READY = 7'h40
  } init_t;

  generate
    if (ADDR_BITS < 1 || ADDR_BITS > spi_seq_pkg::HALF_SEL_BIT)
    begin : bad_addr_bits
      $error("ADDR_BITS must be 1 to 8");
    end
  endgenerate

  init_t state_reg;
  init_t state_next;
  logic [4:0] cnt_reg;
  logic [22:0] in_shift_reg;
  logic [15:0] out_shift_reg;
  logic miso_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] addr_reg;
  logic [15:0] data_reg;
  logic [15:0] wake_reg;
  logic [15:0] sleep_reg;
  logic [15:0] rd_half_reg;
  logic [2*DEPTH-1:0] erased_reg;
  logic pd_reg;
  logic [spi_seq_pkg::WORD_BITS-1:0] mem [DEPTH];
  logic [1:0] test_en_s;

  // Frame logic is held in reset outside a frame or without test mode
  wire frame_rst_n = presetn & ~link.sel_n & link.monitor_test_enable & link.memory_test_enable;

  // Completed address and frame contents
  wire [7:0] frame_addr = {in_shift_reg[6:0], link.mosi};
  wire commit = (cnt_reg == spi_seq_pkg::CNT_LAST);
  wire [7:0] wr_addr = in_shift_reg[22:15];
  wire [15:0] wr_data = {in_shift_reg[14:0], link.mosi};
  wire wr_ctrl = commit && wr_addr == spi_seq_pkg::REG_CTRL;
  wire wr_wake = commit && wr_addr == spi_seq_pkg::REG_WAKE;
  wire wr_sleep = commit && wr_addr == spi_seq_pkg::REG_SLEEP;
  wire reading = (ctrl_reg == spi_seq_pkg::CTRL_READ);
  // Dummy data of a read does not overwrite the data register
  wire wr_data_reg = commit && wr_addr == spi_seq_pkg::REG_DATA && !reading;
  wire wr_addr_reg = commit && wr_addr == spi_seq_pkg::REG_ADDR;
  wire ready = (state_reg == ST_READY);

  // Selected word and half
  wire [ADDR_BITS-1:0] word_idx = addr_reg[ADDR_BITS-1:0];
  wire half_hi = addr_reg[spi_seq_pkg::HALF_SEL_BIT];
  wire [spi_seq_pkg::WORD_BITS-1:0] cur_word = mem[word_idx];
  wire [15:0] cur_half = half_hi ? cur_word[31:16] : cur_word[15:0];
  wire [$clog2(2*DEPTH)-1:0] flag_idx = {word_idx, half_hi};

  wire do_erase = wr_ctrl && ready && wr_data == spi_seq_pkg::CTRL_ERASE;
  wire do_write = wr_ctrl && ready && wr_data == spi_seq_pkg::CTRL_WRITE && erased_reg[flag_idx];
  wire do_read = wr_ctrl && ready && wr_data == spi_seq_pkg::CTRL_READ;

  // Value presented on the data phase of a frame
  function automatic logic [15:0] reg_value(input logic [7:0] a, input logic [15:0] c, input logic [15:0] ad,
                                            input logic [15:0] d, input logic [15:0] w, input logic [15:0] s,
                                            input logic [15:0] rd, input logic rdg);
    case (a)
      spi_seq_pkg::REG_CTRL: reg_value = c;
      spi_seq_pkg::REG_ADDR: reg_value = ad;
      spi_seq_pkg::REG_DATA: reg_value = rdg ? rd : d;
      spi_seq_pkg::REG_WAKE: reg_value = w;
      spi_seq_pkg::REG_SLEEP: reg_value = s;
      default: reg_value = spi_seq_pkg::VAL_CLEAR;
    endcase
  endfunction

  // Frame shift engine, rising-edge sampling
  always_ff @(posedge link.sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      cnt_reg <= '0;
      in_shift_reg <= '0;
      out_shift_reg <= '0;
      miso_reg <= 1'b0;
    end
    else
    begin
      in_shift_reg <= {in_shift_reg[21:0], link.mosi};
      if (cnt_reg != spi_seq_pkg::FRAME_BITS[4:0])
      begin
        cnt_reg <= cnt_reg + 5'h01;
      end
      if (cnt_reg == spi_seq_pkg::CNT_ADDR_LAST)
      begin
        out_shift_reg <= reg_value(frame_addr, ctrl_reg, addr_reg, data_reg, wake_reg, sleep_reg,
                                   rd_half_reg, reading);
      end
      else if (cnt_reg >= spi_seq_pkg::CNT_DATA_FIRST && cnt_reg <= spi_seq_pkg::CNT_LAST)
      begin
        miso_reg <= out_shift_reg[15];
        out_shift_reg <= {out_shift_reg[14:0], 1'b0};
      end
    end
  end

  assign link.miso = miso_reg;

  // Initialisation and disable tracking
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: if (wr_wake && wr_data == spi_seq_pkg::VAL_WAKE) state_next = ST_WOKEN;
      ST_WOKEN: if (wr_wake && wr_data == spi_seq_pkg::VAL_CLEAR) state_next = ST_WAKE_CLR;
      ST_WAKE_CLR: if (wr_sleep && wr_data == spi_seq_pkg::VAL_SLEEP_RESET) state_next = ST_SLEPT;
      ST_SLEPT: if (wr_ctrl && wr_data == spi_seq_pkg::VAL_CLEAR) state_next = ST_CTRL_CLR;
      ST_CTRL_CLR: if (wr_addr_reg && wr_data == spi_seq_pkg::VAL_CLEAR) state_next = ST_ADDR_CLR;
      ST_ADDR_CLR: if (wr_data_reg && wr_data == spi_seq_pkg::VAL_CLEAR) state_next = ST_READY;
      ST_READY: if (wr_wake && wr_data == spi_seq_pkg::VAL_POWERDOWN && sleep_reg == spi_seq_pkg::VAL_SLEEP_RESET)
        state_next = ST_OFF;
      default: state_next = ST_OFF;
    endcase
    // A fresh wake restarts the sequence from any point
    if (wr_wake && wr_data == spi_seq_pkg::VAL_WAKE)
    begin
      state_next = ST_WOKEN;
    end
  end

  always_ff @(posedge link.sclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_OFF;
      ctrl_reg <= '0;
      addr_reg <= '0;
      data_reg <= '0;
      wake_reg <= '0;
      sleep_reg <= '0;
      rd_half_reg <= '0;
      erased_reg <= '0;
      pd_reg <= 1'b0;
      link_ready <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      link_ready <= (state_next == ST_READY);
      if (wr_ctrl) ctrl_reg <= wr_data;
      if (wr_addr_reg) addr_reg <= wr_data;
      if (wr_data_reg) data_reg <= wr_data;
      if (wr_wake) wake_reg <= wr_data;
      if (wr_sleep) sleep_reg <= wr_data;
      if (wr_wake && wr_data == spi_seq_pkg::VAL_POWERDOWN) pd_reg <= 1'b1;
      else if (wr_wake && wr_data == spi_seq_pkg::VAL_WAKE) pd_reg <= 1'b0;
      if (do_erase) erased_reg[flag_idx] <= 1'b1;
      else if (do_write) erased_reg[flag_idx] <= 1'b0;
      if (do_read) rd_half_reg <= cur_half;
    end
  end

  // Store: each command touches only the selected half
  always_ff @(posedge link.sclk)
  begin
    if (do_erase && half_hi) mem[word_idx][31:16] <= spi_seq_pkg::ERASED_HALF;
    if (do_erase && !half_hi) mem[word_idx][15:0] <= spi_seq_pkg::ERASED_HALF;
    if (do_write && half_hi) mem[word_idx][31:16] <= data_reg;
    if (do_write && !half_hi) mem[word_idx][15:0] <= data_reg;
  end

  // Test-mode flag seen in the free-running domain
  sync2 #(.WIDTH(2)) test_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({link.monitor_test_enable, link.memory_test_enable}),
    .q(test_en_s)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      monitor_halted <= 1'b0;
    end
    else
    begin
      monitor_halted <= &test_en_s;
    end
  end

  assign powered_down = pd_reg;
endmodule

// ===== hdl/mem_host.sv
// Host controller: APB slave that runs init, disable, write and read
// sequences as serial frames. Makes the link clock by division of pclk.
`timescale 1ns/100ps
module mem_host #(
  parameter int HALF_CYCLES = spi_seq_pkg::SCLK_HALF_CYCLES,
  parameter int WAIT_CYCLES = spi_seq_pkg::PROG_WAIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  spi_link_if.host link
);
  typedef enum logic [3:0] {H_IDLE = 4'h1, H_LOAD = 4'h2, H_FRAME = 4'h4, H_GAP = 4'h8} hstate_t;
  localparam int CW = $clog2(WAIT_CYCLES + HALF_CYCLES + 1);

  generate
    if (HALF_CYCLES < 1 || WAIT_CYCLES < 1)
    begin : bad_timing
      $error("HALF_CYCLES and WAIT_CYCLES must be at least 1");
    end
  endgenerate

  hstate_t state_reg;
  logic [1:0] op_reg;
  logic [8:0] maddr_reg;
  logic [15:0] mdata_reg;
  logic [2:0] step_reg;
  logic [23:0] tx_reg;
  logic [15:0] rx_reg;
  logic [15:0] rdata_reg;
  logic [CW-1:0] div_reg;
  logic [4:0] bit_reg;
  logic wait_reg;
  logic last_reg;
  logic ready_reg;
  logic test_reg;
  logic sclk_reg;
  logic sel_n_reg;
  logic mosi_reg;
  logic miso_s;

  // Sequence table: {last, wait_after, addr8, data16}
  function automatic logic [25:0] step(input logic [1:0] op, input logic [2:0] i, input logic [8:0] a,
                                       input logic [15:0] d);
    logic [15:0] av;
    av = {7'h00, a};
    step = {2'b00, spi_seq_pkg::REG_CTRL, spi_seq_pkg::CTRL_MEM};
    case (op)
      spi_seq_pkg::OP_INIT:
        case (i)
          3'h0: step = {2'b00, spi_seq_pkg::REG_WAKE, spi_seq_pkg::VAL_WAKE};
          3'h1: step = {2'b00, spi_seq_pkg::REG_WAKE, spi_seq_pkg::VAL_CLEAR};
          3'h2: step = {2'b00, spi_seq_pkg::REG_SLEEP, spi_seq_pkg::VAL_SLEEP_RESET};
          3'h3: step = {2'b00, spi_seq_pkg::REG_CTRL, spi_seq_pkg::VAL_CLEAR};
          3'h4: step = {2'b00, spi_seq_pkg::REG_ADDR, spi_seq_pkg::VAL_CLEAR};
          default: step = {2'b10, spi_seq_pkg::REG_DATA, spi_seq_pkg::VAL_CLEAR};
        endcase
      spi_seq_pkg::OP_DISABLE:
        case (i)
          3'h0: step = {2'b00, spi_seq_pkg::REG_SLEEP, spi_seq_pkg::VAL_SLEEP_RESET};
          3'h1: step = {2'b00, spi_seq_pkg::REG_WAKE, spi_seq_pkg::VAL_POWERDOWN};
          default: step = {2'b10, spi_seq_pkg::REG_WAKE, spi_seq_pkg::VAL_CLEAR};
        endcase
      spi_seq_pkg::OP_WRITE:
        case (i)
          3'h1: step = {2'b00, spi_seq_pkg::REG_ADDR, av};
          3'h2: step = {2'b00, spi_seq_pkg::REG_DATA, d};
          3'h3: step = {2'b01, spi_seq_pkg::REG_CTRL, spi_seq_pkg::CTRL_ERASE};
          3'h5: step = {2'b01, spi_seq_pkg::REG_CTRL, spi_seq_pkg::CTRL_WRITE};
          3'h6: step = {2'b10, spi_seq_pkg::REG_CTRL, spi_seq_pkg::CTRL_MEM};
          default: step = {2'b00, spi_seq_pkg::REG_CTRL, spi_seq_pkg::CTRL_MEM};
        endcase
      default:
        case (i)
          3'h1: step = {2'b00, spi_seq_pkg::REG_ADDR, av};
          3'h2: step = {2'b00, spi_seq_pkg::REG_CTRL, spi_seq_pkg::CTRL_READ};
          3'h3: step = {2'b00, spi_seq_pkg::REG_DATA, spi_seq_pkg::VAL_CLEAR};
          3'h4: step = {2'b10, spi_seq_pkg::REG_CTRL, spi_seq_pkg::CTRL_MEM};
          default: step = {2'b00, spi_seq_pkg::REG_CTRL, spi_seq_pkg::CTRL_MEM};
        endcase
    endcase
  endfunction

  wire busy = (state_reg != H_IDLE);
  wire wr_access = psel && penable && pwrite;
  wire start = wr_access && paddr == spi_seq_pkg::OFS_CMD && !busy;
  wire [25:0] cur_step = step(op_reg, step_reg, maddr_reg, mdata_reg);
  wire half_done = (div_reg == CW'(HALF_CYCLES - 1));
  wire gap_done = (div_reg == (wait_reg ? CW'(WAIT_CYCLES - 1) : CW'(HALF_CYCLES - 1)));
  wire capture = (op_reg == spi_seq_pkg::OP_READ) && step_reg == 3'h3;
  wire [31:0] rd_mux = (paddr == spi_seq_pkg::OFS_STATUS) ? {30'h0, ready_reg, busy} :
                       (paddr == spi_seq_pkg::OFS_RDATA) ? {16'h0000, rdata_reg} :
                       (paddr == spi_seq_pkg::OFS_TEST) ? {31'h0, test_reg} : 32'h0000_0000;

  sync2 #(.WIDTH(1)) miso_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link.miso),
    .q(miso_s)
  );

  // APB slave, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      test_reg <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      prdata <= rd_mux;
      if (wr_access && paddr == spi_seq_pkg::OFS_TEST) test_reg <= pwdata[0];
    end
  end

  // Sequencer and frame engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= H_IDLE;
      op_reg <= '0;
      maddr_reg <= '0;
      mdata_reg <= '0;
      step_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
      rdata_reg <= '0;
      div_reg <= '0;
      bit_reg <= '0;
      wait_reg <= 1'b0;
      last_reg <= 1'b0;
      ready_reg <= 1'b0;
      sclk_reg <= 1'b0;
      sel_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        H_IDLE:
          if (start)
          begin
            op_reg <= pwdata[spi_seq_pkg::CMD_OP_LSB +: 2];
            maddr_reg <= pwdata[spi_seq_pkg::CMD_ADDR_LSB +: 9];
            mdata_reg <= pwdata[spi_seq_pkg::CMD_DATA_LSB +: 16];
            step_reg <= '0;
            state_reg <= H_LOAD;
          end
        H_LOAD:
        begin
          {last_reg, wait_reg} <= cur_step[25:24];
          tx_reg <= {cur_step[22:0], 1'b0};
          mosi_reg <= cur_step[23];
          sel_n_reg <= 1'b0;
          div_reg <= '0;
          bit_reg <= '0;
          state_reg <= H_FRAME;
        end
        H_FRAME:
          if (half_done)
          begin
            div_reg <= '0;
            sclk_reg <= !sclk_reg;
            if (sclk_reg)
            begin
              rx_reg <= {rx_reg[14:0], miso_s};
              mosi_reg <= tx_reg[23];
              tx_reg <= {tx_reg[22:0], 1'b0};
              bit_reg <= bit_reg + 5'h01;
              if (bit_reg == spi_seq_pkg::CNT_LAST) state_reg <= H_GAP;
            end
          end
          else
          begin
            div_reg <= div_reg + CW'(1);
          end
        H_GAP:
        begin
          sel_n_reg <= 1'b1;
          mosi_reg <= 1'b0;
          if (capture) rdata_reg <= rx_reg;
          if (gap_done)
          begin
            div_reg <= '0;
            step_reg <= step_reg + 3'h1;
            if (last_reg)
            begin
              ready_reg <= (op_reg != spi_seq_pkg::OP_DISABLE);
              state_reg <= H_IDLE;
            end
            else
            begin
              state_reg <= H_LOAD;
            end
          end
          else
          begin
            div_reg <= div_reg + CW'(1);
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_reg;
  assign link.sel_n = sel_n_reg;
  assign link.mosi = mosi_reg;
  assign link.monitor_test_enable = test_reg;
  assign link.memory_test_enable = test_reg;
endmodule

// ===== hdl/spi_link_if.sv
// Serial link between the controller (host) and the memory device.
// Assumes the host drives the clock, select, data-in and test enables.
`timescale 1ns/100ps
interface spi_link_if;
  logic sclk;
  logic sel_n;
  logic mosi;
  logic miso;
  logic monitor_test_enable;
  logic memory_test_enable;
  modport device (input sclk, input sel_n, input mosi, output miso,
                  input monitor_test_enable, input memory_test_enable);
  modport host (output sclk, output sel_n, output mosi, input miso,
                output monitor_test_enable, output memory_test_enable);
endinterface

// ===== hdl/spi_seq_pkg.sv
// Shared constants for the serial memory-access link: register map,
// command words, frame layout and timing. Assumes a 50 MHz host clock.
package spi_seq_pkg;
  // Device registers, addressed by the 8-bit frame address
  localparam logic [7:0] REG_CTRL = 8'h01;
  localparam logic [7:0] REG_ADDR = 8'h02;
  localparam logic [7:0] REG_DATA = 8'h03;
  localparam logic [7:0] REG_WAKE = 8'h06;
  localparam logic [7:0] REG_SLEEP = 8'h20;
  // Data words of the command sequences
  localparam logic [15:0] VAL_CLEAR = 16'h0000;
  localparam logic [15:0] VAL_WAKE = 16'h8000;
  localparam logic [15:0] VAL_POWERDOWN = 16'h4000;
  localparam logic [15:0] VAL_SLEEP_RESET = 16'h0018;
  localparam logic [15:0] CTRL_MEM = 16'h00C0;
  localparam logic [15:0] CTRL_ERASE = 16'h00C8;
  localparam logic [15:0] CTRL_WRITE = 16'h00C2;
  localparam logic [15:0] CTRL_READ = 16'h00C1;
  localparam logic [15:0] ERASED_HALF = 16'hFFFF;
  // Frame layout
  localparam int FRAME_ADDR_BITS = 8;
  localparam int FRAME_DATA_BITS = 16;
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
  localparam logic [4:0] CNT_LAST = 5'h17;
  localparam int HALF_SEL_BIT = 8;
  localparam int MEM_ADDR_BITS = 8;
  localparam int WORD_BITS = 32;
  // Timing
  localparam int PCLK_HZ = 50_000_000;
  localparam int LINK_MAX_HZ = 1_000_000;
  localparam int SCLK_HALF_CYCLES = (PCLK_HZ + 2 * LINK_MAX_HZ - 1) / (2 * LINK_MAX_HZ);
  localparam int PROG_WAIT_US = 4000;
  localparam int PROG_WAIT_CYCLES = PROG_WAIT_US * (PCLK_HZ / 1_000_000);
  // Host APB map
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_RDATA = 12'h008;
  localparam logic [11:0] OFS_TEST = 12'h00C;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CMD_OP_LSB = 28;
  localparam int STAT_BUSY = 0;
  localparam int STAT_READY = 1;
  typedef enum logic [1:0] {OP_INIT = 2'h0, OP_DISABLE = 2'h1, OP_WRITE = 2'h2, OP_READ = 2'h3} op_t;
endpackage

// ===== hdl/sync2.sv
// Two-stage synchroniser for level signals.
// Assumes the inputs are levels that stay long compared with the clock.
`timescale 1ns/100ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ===== verif/mem_link_checker.sv
// Checker for the serial link between the host controller and the memory device.
// Assumes a host link clock with a half period of 4 pclk cycles.
`timescale 1ns/100ps
module mem_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic monitor_test_enable,
  input wire logic memory_test_enable
);
  logic sclk_q;
  logic [4:0] rise_cnt;
  wire logic clk_rose = sclk & ~sclk_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Link clock rises counted within one frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_q <= 1'b0;
      rise_cnt <= 5'h00;
    end
    else
    begin
      sclk_q <= sclk;
      rise_cnt <= sel_n ? 5'h00 : rise_cnt + 5'(clk_rose);
    end
  end

  a_sel_fall_low: assert property ($fell(sel_n) |-> !sclk ##1 !sclk)
    else $error("link clock high as select fell");
  a_clk_idle_low: assert property (sel_n |-> !sclk)
    else $error("link clock runs outside a frame");
  a_high_phase: assert property ($rose(sclk) |-> sclk [*4])
    else $error("link clock high phase too short");
  a_low_phase: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("link clock low phase too short");
  a_frame_length: assert property ($rose(sel_n) |-> rise_cnt == 5'h18)
    else $error("frame without 24 clock pulses");
  a_mosi_hold: assert property (!sel_n && sclk && $past(sclk) |-> $stable(mosi))
    else $error("data in changed while clock high");
  a_miso_hold: assert property (!sel_n && sclk && $past(sclk) |-> $stable(miso))
    else $error("data out changed while clock high");
  a_miso_quiet: assert property (sel_n && $past(sel_n) |-> !miso)
    else $error("data out not low outside a frame");
  a_frame_enabled: assert property (!sel_n |-> monitor_test_enable && memory_test_enable)
    else $error("frame sent with test enables low");
  a_enables_pair: assert property (monitor_test_enable == memory_test_enable)
    else $error("test enables differ");
endmodule

// ===== verif/test_spi_eeprom_access_sequencer.sv
// Testbench: host controller and memory device joined over the link, driven over APB.
// Assumes short link and programming waits set through parameters.
`timescale 1ns/100ps
module test_spi_eeprom_access_sequencer;
  localparam int CEILING = 80000;
  logic pclk = 1'b0;
  logic presetn;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, monitor_halted, link_ready, powered_down;
  logic [31:0] q;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  spi_link_if link();
  mem_host #(.HALF_CYCLES(4), .WAIT_CYCLES(50)) mem_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  mem_device mem_device_i (.pclk(pclk), .presetn(presetn), .link(link), .monitor_halted(monitor_halted),
    .link_ready(link_ready), .powered_down(powered_down));
  mem_link_checker mem_link_checker_i (.pclk(pclk), .presetn(presetn), .sclk(link.sclk), .sel_n(link.sel_n),
    .mosi(link.mosi), .miso(link.miso), .monitor_test_enable(link.monitor_test_enable),
    .memory_test_enable(link.memory_test_enable));

  initial
  begin
    forever #10 pclk = ~pclk;
  end

  task give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == CEILING)
    begin
      errors++;
      give_verdict();
    end
  end

  task check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task check_flag(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask

  // One APB transfer; request held until pready is seen high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task do_op(input spi_seq_pkg::op_t op, input logic [8:0] a, input logic [15:0] d);
    int n;
    n = 0;
    apb(1'b1, spi_seq_pkg::OFS_CMD, {2'h0, op, 3'h0, a, d});
    do
    begin
      apb(1'b0, spi_seq_pkg::OFS_STATUS, 32'h00000000);
      n++;
    end
    while (q[spi_seq_pkg::STAT_BUSY] !== 1'b0 && n < 2000);
    check_flag(q[spi_seq_pkg::STAT_BUSY], 1'b0);
  endtask

  task read_half(input logic [8:0] a, input logic [15:0] exp);
    do_op(spi_seq_pkg::OP_READ, a, 16'h0000);
    apb(1'b0, spi_seq_pkg::OFS_RDATA, 32'h00000000);
    check_word({16'h0000, q[15:0]}, {16'h0000, exp});
  endtask

  task t_enable();
    apb(1'b1, spi_seq_pkg::OFS_TEST, 32'h00000001);
    apb(1'b0, spi_seq_pkg::OFS_TEST, 32'h00000000);
    check_word(q, 32'h00000001);
    repeat (4) @(posedge pclk);
    check_flag(monitor_halted, 1'b1);
    check_flag(link_ready, 1'b0);
    $display("test enable done");
  endtask

  task t_init();
    do_op(spi_seq_pkg::OP_INIT, 9'h000, 16'h0000);
    check_flag(link_ready, 1'b1);
    check_flag(q[spi_seq_pkg::STAT_READY], 1'b1);
    check_flag(powered_down, 1'b0);
    $display("test init done");
  endtask

  task t_words();
    logic [8:0] a [4] = '{9'h003, 9'h103, 9'h0FF, 9'h1FF};
    logic [15:0] d [4] = '{16'h123A, 16'hE017, 16'h0001, 16'hFFFE};
    foreach (a[i])
      do_op(spi_seq_pkg::OP_WRITE, a[i], d[i]);
    foreach (a[i])
      read_half(a[i], d[i]);
    do_op(spi_seq_pkg::OP_WRITE, 9'h003, 16'h5A5A);
    read_half(9'h103, 16'hE017);
    read_half(9'h003, 16'h5A5A);
    $display("test words done");
  endtask

  task t_busy();
    apb(1'b1, spi_seq_pkg::OFS_CMD, {2'h0, spi_seq_pkg::OP_READ, 3'h0, 9'h103, 16'h0000});
    do_op(spi_seq_pkg::OP_READ, 9'h0FF, 16'h0000);
    apb(1'b0, spi_seq_pkg::OFS_RDATA, 32'h00000000);
    check_word({16'h0000, q[15:0]}, 32'h0000E017);
    $display("test busy done");
  endtask

  task t_disable();
    do_op(spi_seq_pkg::OP_DISABLE, 9'h000, 16'h0000);
    check_flag(powered_down, 1'b1);
    check_flag(q[spi_seq_pkg::STAT_READY], 1'b0);
    do_op(spi_seq_pkg::OP_WRITE, 9'h0FF, 16'hBEEF);
    do_op(spi_seq_pkg::OP_INIT, 9'h000, 16'h0000);
    check_flag(powered_down, 1'b0);
    read_half(9'h0FF, 16'h0001);
    $display("test disable done");
  endtask

  task t_bus();
    apb(1'b0, 12'h010, 32'h00000000);
    check_word(q, 32'h00000000);
    check_flag(pslverr, 1'b0);
    apb(1'b1, spi_seq_pkg::OFS_TEST, 32'h00000000);
    repeat (4) @(posedge pclk);
    check_flag(monitor_halted, 1'b0);
    $display("test bus done");
  endtask

  initial
  begin
    // Falling edge from unknown resets the link-clocked flops too
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_enable();
    t_init();
    t_words();
    t_busy();
    t_disable();
    t_bus();
    give_verdict();
  end
endmodule
